/* common/sca_cfg_if.sv */
/*
  Carrier for one block's two control bytes between bank and switch logic.
  Assumes the bank drives it and one switch module reads it.
*/
`timescale 1ns/1ps
interface sca_cfg_if;
  logic [7:0] ctrl2;
  logic [7:0] ctrl3;
  modport bank (output ctrl2, output ctrl3);
  modport sw (input ctrl2, input ctrl3);
endinterface

/* common/sca_pkg.sv */
/*
  Constants for the type-A switched-capacitor control register bank:
  register offsets, field positions, reset values and encodings.
  Assumes an 8-bit register port whose address ignores the bank select.
*/
// How it works
// - c path cap size field is an unsigned count of 0 to 31 units
// - second control registers sit at 82h 8Ah 96h 9Eh in either bank
// - third control registers sit at 83h 8Bh 97h 9Fh in either bank
// - power level field resets to zero so every block starts off
// - power codes: 00 off, 01 low, 10 medium, 11 high bias
// - reference select bits 7:6: ground, high, low, comparator driven
// - comparator driven reference picks high when comparator high, else low
// - integrator feedback gate cleared holds that switch off always
// - gate set: switch on always, or only in phase two with offset null
// - ground feedback gate set enables ground switch only during phase one
// - b input select bits 3:2 pick one of four per-block sources
// - offset null bit 5 enables shorting switch during phase one only
// - bit 6 of second control gates drive onto comparator bus
// - comparator sampled at phase one rise, held through phase two
package sca_pkg;
  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam int NUM_BLK = 4;
  localparam logic [7:0] ADDR_BLK10_CTRL2 = 8'h82;
  localparam logic [7:0] ADDR_BLK10_CTRL3 = 8'h83;
  localparam logic [7:0] ADDR_BLK12_CTRL2 = 8'h8A;
  localparam logic [7:0] ADDR_BLK12_CTRL3 = 8'h8B;
  localparam logic [7:0] ADDR_BLK21_CTRL2 = 8'h96;
  localparam logic [7:0] ADDR_BLK21_CTRL3 = 8'h97;
  localparam logic [7:0] ADDR_BLK23_CTRL2 = 8'h9E;
  localparam logic [7:0] ADDR_BLK23_CTRL3 = 8'h9F;
  localparam logic [7:0] RST_CTRL2 = 8'h00;
  localparam logic [7:0] RST_CTRL3 = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int CR2_COMP_BIT = 6;
  localparam int CR2_NULL_BIT = 5;
  localparam int CR2_CAP_MSB = 4;
  localparam int CR3_REF_MSB = 7;
  localparam int CR3_REF_LSB = 6;
  localparam int CR3_INTEGRATOR_FEEDBACK_SWITCH_GATE_BIT = 5;
  localparam int CR3_GROUND_FEEDBACK_SWITCH_GATE_BIT = 4;
  localparam int CR3_BSEL_MSB = 3;
  localparam int CR3_BSEL_LSB = 2;
  localparam int CR3_PWR_MSB = 1;
  // -------------------------------------------------------------------------
  // encodings
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCA_REF_GND = 2'h0,
    SCA_REF_HIGH = 2'h1,
    SCA_REF_LOW = 2'h2,
    SCA_REF_COMP = 2'h3
  } sca_ref_t;
  typedef enum logic [1:0] {
    SCA_PWR_OFF = 2'h0,
    SCA_PWR_LOW = 2'h1,
    SCA_PWR_MED = 2'h2,
    SCA_PWR_HIGH = 2'h3
  } sca_pwr_t;
endpackage

/* rtl/sca_comp_latch.sv */
/*
  Comparator latch for one block: samples on the rise of phase one.
  Assumes phase inputs are synchronous levels of clk_i.
*/
`timescale 1ns/1ps
module sca_comp_latch (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic phase_one_i,
  input wire logic comp_raw_i,
  output logic comp_o
);
  logic ph1_q;
  logic comp_q;
  wire ph1_rise = phase_one_i & ~ph1_q;
  // -------------------------------------------------------------------------
  // edge detect and latch
  // -------------------------------------------------------------------------
  // the latched value stays put through phase two so the mux never glitches
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph1_q <= 1'b0;
      comp_q <= 1'b0;
    end else begin
      ph1_q <= phase_one_i;
      if (ph1_rise) begin
        comp_q <= comp_raw_i;
      end
    end
  end
  assign comp_o = comp_q;
  AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ph1_rise |=> comp_q == $past(comp_q)) else $error("latch moved off edge");
endmodule

/* rtl/sca_regs.sv */
/*
  Type-A switched-capacitor control register bank with per-block switch
  gating. Assumes a simple strobe port, data one cycle after the read
  strobe, and that the bank select bit is not part of the address.
*/
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module sca_regs (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic phase_one_i,
  input wire logic phase_two_i,
  input wire logic [3:0] comp_raw_i,
  output logic [3:0] int_fb_sw_o,
  output logic [3:0] gnd_fb_sw_o,
  output logic [3:0] short_sw_o,
  output logic [3:0] comp_bus_en_o,
  output logic [7:0] ref_sel_o,
  output logic [7:0] b_input_select_o,
  output logic [7:0] power_o,
  output logic [19:0] cap_o,
  output logic [3:0] comp_latched_o
);
  localparam int N = sca_pkg::NUM_BLK;
  localparam logic [7:0] ADDR2 [N] = '{sca_pkg::ADDR_BLK10_CTRL2, sca_pkg::ADDR_BLK12_CTRL2,
    sca_pkg::ADDR_BLK21_CTRL2, sca_pkg::ADDR_BLK23_CTRL2};
  localparam logic [7:0] ADDR3 [N] = '{sca_pkg::ADDR_BLK10_CTRL3, sca_pkg::ADDR_BLK12_CTRL3,
    sca_pkg::ADDR_BLK21_CTRL3, sca_pkg::ADDR_BLK23_CTRL3};

  logic [7:0] ctrl2_q [N];
  logic [7:0] ctrl3_q [N];
  logic [7:0] rdata_q;
  logic [N-1:0] hit2;
  logic [N-1:0] hit3;
  logic [7:0] rd_mux;

  // -------------------------------------------------------------------------
  // decode and read select
  // -------------------------------------------------------------------------
  // one-hot hits; an address outside the map reads zero and writes nothing
  always_comb begin
    rd_mux = sca_pkg::RD_UNMAPPED;
    for (int i = 0; i < N; i++) begin
      hit2[i] = (addr_i == ADDR2[i]);
      hit3[i] = (addr_i == ADDR3[i]);
      if (hit2[i]) begin
        rd_mux = ctrl2_q[i];
      end
      if (hit3[i]) begin
        rd_mux = ctrl3_q[i];
      end
    end
  end

  // -------------------------------------------------------------------------
  // register storage
  // -------------------------------------------------------------------------
  // all bits clear at reset, so power sits at off until software writes it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < N; i++) begin
        ctrl2_q[i] <= sca_pkg::RST_CTRL2;
        ctrl3_q[i] <= sca_pkg::RST_CTRL3;
      end
    end else if (wr_i) begin
      for (int i = 0; i < N; i++) begin
        if (hit2[i]) begin
          ctrl2_q[i] <= wdata_i;
        end
        if (hit3[i]) begin
          ctrl3_q[i] <= wdata_i;
        end
      end
    end
  end

  // read data appear only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_i ? rd_mux : 8'h00;
    end
  end
  assign rdata_o = rdata_q;

  // -------------------------------------------------------------------------
  // per-block switch logic
  // -------------------------------------------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_blk
    sca_cfg_if cfg ();
    logic comp_l;
    assign cfg.ctrl2 = ctrl2_q[g];
    assign cfg.ctrl3 = ctrl3_q[g];
    sca_comp_latch u_latch (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .phase_one_i(phase_one_i),
      .comp_raw_i(comp_raw_i[g]),
      .comp_o(comp_l)
    );
    sca_switch_ctl u_sw (
      .cfg(cfg),
      .phase_one_i(phase_one_i),
      .phase_two_i(phase_two_i),
      .comp_i(comp_l),
      .int_fb_sw_o(int_fb_sw_o[g]),
      .gnd_fb_sw_o(gnd_fb_sw_o[g]),
      .short_sw_o(short_sw_o[g]),
      .comp_bus_en_o(comp_bus_en_o[g]),
      .ref_sel_o(ref_sel_o[2*g +: 2]),
      .b_input_select_o(b_input_select_o[2*g +: 2]),
      .power_o(power_o[2*g +: 2]),
      .cap_o(cap_o[5*g +: 5])
    );
    assign comp_latched_o[g] = comp_l;
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  sequence s_wr2(int k);
    wr_i && addr_i == ADDR2[k];
  endsequence

  AST_CTRL2_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wr2(0) |=> cap_o[4:0] == $past(wdata_i[4:0])) else $error("cap not written");
  AST_CTRL3_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == ADDR3[3]) |=> power_o[7:6] == $past(wdata_i[1:0]))
    else $error("power not written");
  AST_READBACK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == ADDR2[2] && !wr_i) |=> rdata_o == ctrl2_q[2])
    else $error("readback wrong");
  AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && hit2 == '0 && hit3 == '0) |=> rdata_o == 8'h00) else $error("unmapped nonzero");
  AST_PWR_OFF: assert property (@(posedge clk_i)
    $rose(rst_n_i) |-> power_o == 8'h00) else $error("power not off at reset");
  AST_INT_FB_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ctrl3_q[0][sca_pkg::CR3_INTEGRATOR_FEEDBACK_SWITCH_GATE_BIT] |-> !int_fb_sw_o[0]) else $error("int sw on");
  AST_INT_FB_NULL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ctrl3_q[1][sca_pkg::CR3_INTEGRATOR_FEEDBACK_SWITCH_GATE_BIT] && ctrl2_q[1][sca_pkg::CR2_NULL_BIT])
    |-> int_fb_sw_o[1] == phase_two_i) else $error("int sw phase");
  AST_GND_FB: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    gnd_fb_sw_o[2] == (ctrl3_q[2][sca_pkg::CR3_GROUND_FEEDBACK_SWITCH_GATE_BIT] && phase_one_i))
    else $error("gnd sw wrong");
  AST_SHORT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    short_sw_o[3] |-> phase_one_i && ctrl2_q[3][sca_pkg::CR2_NULL_BIT])
    else $error("short sw wrong");
  AST_REF_COMP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl3_q[0][7:6] == 2'h3 |-> ref_sel_o[1:0] == (comp_latched_o[0] ? 2'h1 : 2'h2))
    else $error("comp ref wrong");
  AST_COMP_BUS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    comp_bus_en_o[1] == ctrl2_q[1][sca_pkg::CR2_COMP_BIT]) else $error("comp bus");
endmodule

/* rtl/sca_switch_ctl.sv */
/*
  Switch gating for one type-A block, pure combinational.
  Assumes non-overlapping phase levels and a latched comparator level.
*/
`timescale 1ns/1ps
module sca_switch_ctl (
  sca_cfg_if.sw cfg,
  input wire logic phase_one_i,
  input wire logic phase_two_i,
  input wire logic comp_i,
  output logic int_fb_sw_o,
  output logic gnd_fb_sw_o,
  output logic short_sw_o,
  output logic comp_bus_en_o,
  output logic [1:0] ref_sel_o,
  output logic [1:0] b_input_select_o,
  output logic [1:0] power_o,
  output logic [4:0] cap_o
);
  wire offset_null_enable = cfg.ctrl2[sca_pkg::CR2_NULL_BIT];
  wire int_gate = cfg.ctrl3[sca_pkg::CR3_INTEGRATOR_FEEDBACK_SWITCH_GATE_BIT];
  wire gnd_gate = cfg.ctrl3[sca_pkg::CR3_GROUND_FEEDBACK_SWITCH_GATE_BIT];
  wire [1:0] a_reference_select = cfg.ctrl3[sca_pkg::CR3_REF_MSB:sca_pkg::CR3_REF_LSB];
  // -------------------------------------------------------------------------
  // gated switches; no flops so they track phases with no added latency
  // -------------------------------------------------------------------------
  assign int_fb_sw_o = int_gate & (~offset_null_enable | phase_two_i);
  assign gnd_fb_sw_o = gnd_gate & phase_one_i;
  assign short_sw_o = offset_null_enable & phase_one_i;
  assign comp_bus_en_o = cfg.ctrl2[sca_pkg::CR2_COMP_BIT];
  // comparator mode resolves to high or low reference, never ground
  assign ref_sel_o = (a_reference_select == sca_pkg::SCA_REF_COMP) ?
    (comp_i ? sca_pkg::SCA_REF_HIGH : sca_pkg::SCA_REF_LOW) : a_reference_select;
  assign b_input_select_o = cfg.ctrl3[sca_pkg::CR3_BSEL_MSB:sca_pkg::CR3_BSEL_LSB];
  assign power_o = cfg.ctrl3[sca_pkg::CR3_PWR_MSB:0];
  assign cap_o = cfg.ctrl2[sca_pkg::CR2_CAP_MSB:0];
endmodule

/* tb/sca_regs_tb.sv */
/*
  Self-checking bench for the type-A switched-capacitor register bank.
  Assumes the strobe register port and phase levels synchronous to clk_i.
*/
`timescale 1ns/1ps
module sca_regs_tb;
  logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic phase_one_i = 1'b0, phase_two_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, ref_sel_o, b_input_select_o, power_o;
  logic [3:0] comp_raw_i = 4'h0, int_fb_sw_o, gnd_fb_sw_o, short_sw_o, comp_bus_en_o;
  logic [3:0] comp_latched_o, lat_m, p1_d;
  logic [19:0] cap_o;
  logic [7:0] m2 [4], m3 [4];
  logic [7:0] a2 [4] = '{sca_pkg::ADDR_BLK10_CTRL2, sca_pkg::ADDR_BLK12_CTRL2,
                         sca_pkg::ADDR_BLK21_CTRL2, sca_pkg::ADDR_BLK23_CTRL2};
  logic [7:0] a3 [4] = '{sca_pkg::ADDR_BLK10_CTRL3, sca_pkg::ADDR_BLK12_CTRL3,
                         sca_pkg::ADDR_BLK21_CTRL3, sca_pkg::ADDR_BLK23_CTRL3};
  logic [15:0] seed = 16'h706B;
  int mismatches = 0, checks_done = 0;
  sca_regs sca_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .phase_one_i(phase_one_i),
    .phase_two_i(phase_two_i), .comp_raw_i(comp_raw_i), .int_fb_sw_o(int_fb_sw_o),
    .gnd_fb_sw_o(gnd_fb_sw_o), .short_sw_o(short_sw_o), .comp_bus_en_o(comp_bus_en_o),
    .ref_sel_o(ref_sel_o), .b_input_select_o(b_input_select_o), .power_o(power_o),
    .cap_o(cap_o), .comp_latched_o(comp_latched_o));
  // -------------------------------------------------------------------------
  // clock and comparator latch model
  // -------------------------------------------------------------------------
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // model samples on the phase one rise; checks wait long enough for either latency
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_m <= 4'h0;
      p1_d <= 4'h0;
    end else begin
      p1_d <= {4{phase_one_i}};
      if (phase_one_i && !p1_d[0]) lat_m <= comp_raw_i;
    end
  end
  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, then drop to zero
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
    @(posedge clk_i);
    #1 chk(rdata_o, 8'h00);
  endtask
  task automatic check_outs();
    logic [3:0] e_int, e_gnd, e_sh, e_cb;
    logic [7:0] e_ref, e_b, e_pw;
    logic [19:0] e_cap;
    for (int b = 0; b < 4; b++) begin
      e_int[b] = m3[b][5] & (~m2[b][5] | phase_two_i);
      e_gnd[b] = m3[b][4] & phase_one_i;
      e_sh[b] = m2[b][5] & phase_one_i;
      e_cb[b] = m2[b][6];
      e_ref[2*b +: 2] = (m3[b][7:6] == 2'h3) ? (lat_m[b] ? 2'h1 : 2'h2) : m3[b][7:6];
      e_b[2*b +: 2] = m3[b][3:2];
      e_pw[2*b +: 2] = m3[b][1:0];
      e_cap[5*b +: 5] = m2[b][4:0];
    end
    chk(int_fb_sw_o, e_int);
    chk(gnd_fb_sw_o, e_gnd);
    chk(short_sw_o, e_sh);
    chk(comp_bus_en_o, e_cb);
    chk(ref_sel_o, e_ref);
    chk(comp_latched_o, lat_m);
    chk(b_input_select_o, e_b);
    chk(power_o, e_pw);
    chk(cap_o, e_cap);
  endtask
  // write one block, read it back, then walk the three phase states
  task automatic step(input int b, input logic [7:0] c2, input logic [7:0] c3);
    wr(a2[b], c2);
    wr(a3[b], c3);
    m2[b] = c2;
    m3[b] = c3;
    rd(a2[b], c2);
    rd(a3[b], c3);
    for (int ph = 0; ph < 3; ph++) begin
      seed = lfsr(seed);
      @(posedge clk_i);
      phase_one_i <= (ph == 1);
      phase_two_i <= (ph == 2);
      comp_raw_i <= seed[3:0];
      repeat (3) @(posedge clk_i);
      #1 check_outs();
      comp_raw_i <= ~comp_raw_i;
      repeat (2) @(posedge clk_i);
      #1 check_outs();
    end
  endtask
  task automatic final_report();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  initial begin
    for (int b = 0; b < 4; b++) begin
      m2[b] = sca_pkg::RST_CTRL2;
      m3[b] = sca_pkg::RST_CTRL3;
    end
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 check_outs();
    for (int b = 0; b < 4; b++) begin
      rd(a2[b], 8'h00);
      rd(a3[b], 8'h00);
    end
    // every reference, power and select code, cap size at both ends
    for (int k = 0; k < 16; k++) begin
      step(k % 4, k[0] ? 8'hFF : 8'h00, {k[1:0], k[2], k[3], k[3:2], k[1:0]});
    end
    wr(8'h84, 8'hFF);
    rd(8'h84, sca_pkg::RD_UNMAPPED);
    rd(a3[3], m3[3]);
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      step(seed[1:0], seed[15:8], seed[7:0] ^ seed[15:8]);
    end
    // second reset in mid-run clears every block back to off
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      m2[b] = 8'h00;
      m3[b] = 8'h00;
    end
    #1 check_outs();
    rd(a3[1], 8'h00);
    final_report();
  end
endmodule
